// file: rtl/supply_map_defines.svh
// offsets, field positions, reset values and codes of the supply register map
`ifndef SUPPLY_MAP_DEFINES_SVH
`define SUPPLY_MAP_DEFINES_SVH

// function codes
`define FC_READ_HOLD    8'h03
`define FC_WRITE_SINGLE 8'h06
`define FC_WRITE_MULTI  8'h10
`define FC_EXC_FLAG     8'h80

// exception codes
`define EXC_ILLEGAL_FUNC 8'h01
`define EXC_ILLEGAL_ADDR 8'h02

// register counts
`define CNT_ONE  16'h0001
`define CNT_TWO  16'h0002
`define CNT_FOUR 16'h0004

// status and output enable
`define ADDR_FAULT_SUMMARY_RD 16'h10b0
`define ADDR_OP_STATUS_RD     16'h10d0
`define ADDR_OUT_EN_WR        16'h10f0
`define ADDR_OUT_EN_RD        16'h1100

// measurements
`define ADDR_MEAS_CURR_RD 16'h2010
`define ADDR_MEAS_VOLT_RD 16'h2020
`define ADDR_MEAS_PWR_RD  16'h2030

// 32-bit settings, write then read address
`define ADDR_CURR_TGT_WR  16'h3010
`define ADDR_CURR_TGT_RD  16'h3020
`define ADDR_VOLT_TGT_WR  16'h3030
`define ADDR_VOLT_TGT_RD  16'h3040
`define ADDR_PWR_TGT_WR   16'h3050
`define ADDR_PWR_TGT_RD   16'h3060
`define ADDR_OC_LIM_WR    16'h4010
`define ADDR_OC_LIM_RD    16'h4020
`define ADDR_OV_LIM_WR    16'h4030
`define ADDR_OV_LIM_RD    16'h4040
`define ADDR_OP_LIM_WR    16'h4050
`define ADDR_OP_LIM_RD    16'h4060
`define ADDR_UV_LIM_WR    16'h4070
`define ADDR_UV_LIM_RD    16'h4080
`define ADDR_CURR_RISE_WR 16'h5010
`define ADDR_CURR_RISE_RD 16'h5020
`define ADDR_VOLT_RISE_WR 16'h5030
`define ADDR_VOLT_RISE_RD 16'h5040
`define ADDR_PWR_RISE_WR  16'h5050
`define ADDR_PWR_RISE_RD  16'h5060
`define ADDR_CURR_FALL_WR 16'h5090
`define ADDR_CURR_FALL_RD 16'h50a0
`define ADDR_VOLT_FALL_WR 16'h50b0
`define ADDR_VOLT_FALL_RD 16'h50c0
`define ADDR_PWR_FALL_WR  16'h50d0
`define ADDR_PWR_FALL_RD  16'h50e0

// 16-bit settings
`define ADDR_REG_SEL_WR   16'h6030
`define ADDR_REG_SEL_RD   16'h6040
`define ADDR_RELOAD_WR    16'h8010
`define ADDR_LOCK_RD      16'h8020
`define ADDR_LOCK_WR      16'h8030
`define ADDR_SENSE_WR     16'h8060
`define ADDR_SENSE_RD     16'h8070
`define ADDR_PROTO_WR     16'h8080
`define ADDR_PROTO_RD     16'h8090
`define ADDR_SOURCE_WR    16'h80a0
`define ADDR_SOURCE_RD    16'h80b0

// fault summary bit positions
`define FS_OVP  0
`define FS_OCT  1
`define FS_OVT  2
`define FS_OPT  3
`define FS_OCP  4
`define FS_OTP  5
`define FS_RSL  6
`define FS_CC   7
`define FS_CV   8
`define FS_CR   9
`define FS_CP   10
`define FS_ANY_SOFT_FAULT 11
`define FS_ANY_HARD_FAULT 12
`define FS_INTERLOCK_OPEN_FLAG 13
`define FS_IPL  14
`define FS_USER_INPUT_FAULT_FLAG 15

// reset and factory values
`define RST_WORD   32'h0000_0000
`define RST_HALF   16'h0000
`define RST_OUT_EN 1'b0

`endif

// file: rtl/supply_map_pkg.sv
// types of the supply register map
package supply_map_pkg;

	localparam int NUM_WORDS = 13;
	localparam int NUM_HALVES = 5;

	typedef struct packed {
		logic [7:0]  func;
		logic [15:0] addr;
		logic [15:0] count;
		logic [31:0] wdata;
	} request_t;

	typedef struct packed {
		logic [7:0]  func;
		logic [15:0] addr;
		logic [15:0] count;
		logic        exc;
		logic [7:0]  exc_code;
		logic [63:0] rdata;
	} response_t;

	// live plant conditions
	typedef struct packed {
		logic overvoltage_protect_flag;
		logic overcurrent_trip_flag;
		logic overvoltage_trip_flag;
		logic overpower_trip_flag;
		logic overcurrent_protect_flag;
		logic overtemp_protect_flag;
		logic sense_line_loss_flag;
		logic undervoltage_trip_flag;
		logic const_current_state;
		logic const_voltage_state;
		logic const_resistance_state;
		logic const_power_state;
		logic interlock_open_flag;
		logic input_power_loss_flag;
		logic user_input_fault_flag;
	} plant_flags_t;

	typedef struct packed {
		logic [31:0] current_measure_query;
		logic [31:0] voltage_measure_query;
		logic [31:0] power_measure_query;
	} measure_t;

	// words: targets, limits, slews; halves: select, lockout, sense, protocol, source
	typedef struct packed {
		logic [NUM_WORDS-1:0][31:0]  word;
		logic [NUM_HALVES-1:0][15:0] half;
		logic                        out_en;
	} settings_t;

	typedef struct packed {
		plant_flags_t flags_s1;
		plant_flags_t flags_s2;
		logic [63:0]  opstat_s1;
		logic [63:0]  opstat_s2;
		settings_t    set;
		response_t    rsp;
		logic         rsp_valid;
		logic         reload;
	} state_t;

endpackage : supply_map_pkg

// file: rtl/supply_register_map.sv
// register map of the programmable supply, request decode and answer
`timescale 1ns/100ps
`include "supply_map_defines.svh"

// Notes on behaviour
// - read answers with value held there
// - write stores value, then acknowledges
// - one value per request, count checked on reads and multi-writes
// - fault summary read-only, two registers
// - fault summary live, read leaves it
// - bits 0-6 protection and trip flags
// - bits 7-10 regulation state
// - bit 11 ORs soft faults
// - bit 12 ORs hard faults
// - bits 13-15 interlock, power loss, input
// - status word read-only, four registers
// - status word live, never cleared
// - summary built from plant flags, not status word
// - targets written and read apart
// - three measurements read-only, consecutive
// - four trip limits write/read paired
// - six slews, own write/read addresses
// - regulation select written, read separately
// - reload write restores defaults, no read
// - sense, protocol, source write/read pairs
// - output enable; reads zero when faulted
// - unmatched address, or unmatched count on reads and multi-writes, gives 0x02
// - most significant register first
module supply_register_map (
	// clock and reset
	input  wire logic                          clk_in,
	input  wire logic                          srst_in,
	// request from the protocol front end
	input  wire logic                          req_valid_in,
	input  wire supply_map_pkg::request_t      req_in,
	// answer to the protocol front end
	output logic                               rsp_valid_out,
	output supply_map_pkg::response_t          rsp_out,
	// plant status, asynchronous pins
	input  wire supply_map_pkg::plant_flags_t  flags_in,
	input  wire logic [63:0]                   opstat_in,
	// measurements, same clock
	input  wire supply_map_pkg::measure_t      meas_in,
	// settings to the regulator
	output supply_map_pkg::settings_t          settings_out,
	output logic                               reload_out
);

	// ----------------------------------------
	// address tables
	// ----------------------------------------
	localparam int NW = supply_map_pkg::NUM_WORDS;
	localparam int NH = supply_map_pkg::NUM_HALVES;

	localparam logic [15:0] WORD_WR [NW] = '{
		`ADDR_CURR_TGT_WR, `ADDR_VOLT_TGT_WR, `ADDR_PWR_TGT_WR,
		`ADDR_OC_LIM_WR, `ADDR_OV_LIM_WR, `ADDR_OP_LIM_WR, `ADDR_UV_LIM_WR,
		`ADDR_CURR_RISE_WR, `ADDR_VOLT_RISE_WR, `ADDR_PWR_RISE_WR,
		`ADDR_CURR_FALL_WR, `ADDR_VOLT_FALL_WR, `ADDR_PWR_FALL_WR
	};

	localparam logic [15:0] WORD_RD [NW] = '{
		`ADDR_CURR_TGT_RD, `ADDR_VOLT_TGT_RD, `ADDR_PWR_TGT_RD,
		`ADDR_OC_LIM_RD, `ADDR_OV_LIM_RD, `ADDR_OP_LIM_RD, `ADDR_UV_LIM_RD,
		`ADDR_CURR_RISE_RD, `ADDR_VOLT_RISE_RD, `ADDR_PWR_RISE_RD,
		`ADDR_CURR_FALL_RD, `ADDR_VOLT_FALL_RD, `ADDR_PWR_FALL_RD
	};

	localparam logic [15:0] HALF_WR [NH] = '{
		`ADDR_REG_SEL_WR, `ADDR_LOCK_WR, `ADDR_SENSE_WR,
		`ADDR_PROTO_WR, `ADDR_SOURCE_WR
	};

	localparam logic [15:0] HALF_RD [NH] = '{
		`ADDR_REG_SEL_RD, `ADDR_LOCK_RD, `ADDR_SENSE_RD,
		`ADDR_PROTO_RD, `ADDR_SOURCE_RD
	};

	// ----------------------------------------
	// factory settings
	// ----------------------------------------
	function automatic supply_map_pkg::settings_t factory_set();
		supply_map_pkg::settings_t s;
		for (int i = 0; i < NW; i++) begin
			s.word[i] = `RST_WORD;
		end
		for (int i = 0; i < NH; i++) begin
			s.half[i] = `RST_HALF;
		end
		s.out_en = `RST_OUT_EN;
		return s;
	endfunction : factory_set

	// ----------------------------------------
	// state
	// ----------------------------------------
	supply_map_pkg::state_t q;
	supply_map_pkg::state_t d;

	logic        soft_any;
	logic        hard_any;
	logic [15:0] summary;

	// ----------------------------------------
	// fault summary, from second sync stage
	// ----------------------------------------
	always_comb begin
		soft_any = q.flags_s2.overcurrent_trip_flag
			| q.flags_s2.overvoltage_trip_flag
			| q.flags_s2.overpower_trip_flag
			| q.flags_s2.undervoltage_trip_flag;
		hard_any = q.flags_s2.overvoltage_protect_flag
			| q.flags_s2.overcurrent_protect_flag
			| q.flags_s2.overtemp_protect_flag
			| q.flags_s2.sense_line_loss_flag;
		summary = 16'h0000;
		// live bits, layout independent of the full status word
		summary[`FS_OVP]  = q.flags_s2.overvoltage_protect_flag;
		summary[`FS_OCT]  = q.flags_s2.overcurrent_trip_flag;
		summary[`FS_OVT]  = q.flags_s2.overvoltage_trip_flag;
		summary[`FS_OPT]  = q.flags_s2.overpower_trip_flag;
		summary[`FS_OCP]  = q.flags_s2.overcurrent_protect_flag;
		summary[`FS_OTP]  = q.flags_s2.overtemp_protect_flag;
		summary[`FS_RSL]  = q.flags_s2.sense_line_loss_flag;
		summary[`FS_CC]   = q.flags_s2.const_current_state;
		summary[`FS_CV]   = q.flags_s2.const_voltage_state;
		summary[`FS_CR]   = q.flags_s2.const_resistance_state;
		summary[`FS_CP]   = q.flags_s2.const_power_state;
		summary[`FS_ANY_SOFT_FAULT] = soft_any;
		summary[`FS_ANY_HARD_FAULT] = hard_any;
		summary[`FS_INTERLOCK_OPEN_FLAG] = q.flags_s2.interlock_open_flag;
		summary[`FS_IPL]  = q.flags_s2.input_power_loss_flag;
		summary[`FS_USER_INPUT_FAULT_FLAG] = q.flags_s2.user_input_fault_flag;
	end

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb begin
		logic        hit;
		logic [15:0] need;
		d = q;
		hit = 1'b0;
		need = `CNT_ONE;
		d.flags_s1 = flags_in;
		d.flags_s2 = q.flags_s1;
		d.opstat_s1 = opstat_in;
		d.opstat_s2 = q.opstat_s1;
		d.rsp_valid = 1'b0;
		d.reload = 1'b0;

		// a soft or hard fault drops the output to standby
		if (soft_any || hard_any) begin
			d.set.out_en = 1'b0;
		end

		if (req_valid_in) begin
			d.rsp_valid = 1'b1;
			d.rsp.func = req_in.func;
			d.rsp.addr = req_in.addr;
			d.rsp.count = req_in.count;
			d.rsp.exc = 1'b0;
			d.rsp.exc_code = 8'h00;
			d.rsp.rdata = 64'h0;

			case (req_in.func)
				`FC_READ_HOLD: begin
					// data right-aligned, high register first
					if (req_in.addr == `ADDR_FAULT_SUMMARY_RD) begin
						hit = 1'b1;
						need = `CNT_TWO;
						d.rsp.rdata = {48'h0, summary};
					end
					if (req_in.addr == `ADDR_OP_STATUS_RD) begin
						hit = 1'b1;
						need = `CNT_FOUR;
						d.rsp.rdata = q.opstat_s2;
					end
					if (req_in.addr == `ADDR_OUT_EN_RD) begin
						hit = 1'b1;
						d.rsp.rdata = {63'h0, q.set.out_en};
					end
					if (req_in.addr == `ADDR_MEAS_CURR_RD) begin
						hit = 1'b1;
						need = `CNT_TWO;
						d.rsp.rdata = {32'h0, meas_in.current_measure_query};
					end
					if (req_in.addr == `ADDR_MEAS_VOLT_RD) begin
						hit = 1'b1;
						need = `CNT_TWO;
						d.rsp.rdata = {32'h0, meas_in.voltage_measure_query};
					end
					if (req_in.addr == `ADDR_MEAS_PWR_RD) begin
						hit = 1'b1;
						need = `CNT_TWO;
						d.rsp.rdata = {32'h0, meas_in.power_measure_query};
					end
					for (int i = 0; i < NW; i++) begin
						if (req_in.addr == WORD_RD[i]) begin
							hit = 1'b1;
							need = `CNT_TWO;
							d.rsp.rdata = {32'h0, q.set.word[i]};
						end
					end
					for (int i = 0; i < NH; i++) begin
						if (req_in.addr == HALF_RD[i]) begin
							hit = 1'b1;
							d.rsp.rdata = {48'h0, q.set.half[i]};
						end
					end
					// one whole value per request
					if (!hit || req_in.count != need) begin
						d.rsp.exc = 1'b1;
						d.rsp.exc_code = `EXC_ILLEGAL_ADDR;
						d.rsp.rdata = 64'h0;
					end
				end

				`FC_WRITE_SINGLE: begin
					// ack echoes the value written
					d.rsp.count = `CNT_ONE;
					d.rsp.rdata = {48'h0, req_in.wdata[15:0]};
					if (req_in.addr == `ADDR_OUT_EN_WR) begin
						hit = 1'b1;
						// enable refused while a soft or hard fault stands
						d.set.out_en = req_in.wdata[0] & ~(soft_any | hard_any);
					end
					if (req_in.addr == `ADDR_RELOAD_WR) begin
						hit = 1'b1;
						d.set = factory_set();
						d.reload = 1'b1;
					end
					for (int i = 0; i < NH; i++) begin
						if (req_in.addr == HALF_WR[i]) begin
							hit = 1'b1;
							d.set.half[i] = req_in.wdata[15:0];
						end
					end
					if (!hit) begin
						d.rsp.exc = 1'b1;
						d.rsp.exc_code = `EXC_ILLEGAL_ADDR;
						d.rsp.rdata = 64'h0;
					end
				end

				`FC_WRITE_MULTI: begin
					for (int i = 0; i < NW; i++) begin
						if (req_in.addr == WORD_WR[i]) begin
							hit = 1'b1;
						end
					end
					if (!hit || req_in.count != `CNT_TWO) begin
						d.rsp.exc = 1'b1;
						d.rsp.exc_code = `EXC_ILLEGAL_ADDR;
					end else begin
						for (int i = 0; i < NW; i++) begin
							if (req_in.addr == WORD_WR[i]) begin
								// high register arrives in wdata[31:16]
								d.set.word[i] = req_in.wdata;
							end
						end
					end
				end

				default: begin
					d.rsp.exc = 1'b1;
					d.rsp.exc_code = `EXC_ILLEGAL_FUNC;
				end
			endcase

			if (d.rsp.exc) begin
				d.rsp.func = req_in.func | `FC_EXC_FLAG;
			end
		end
	end

	// ----------------------------------------
	// registers
	// ----------------------------------------
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			q <= '0;
			q.set <= factory_set();
		end else begin
			q <= d;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign rsp_valid_out = q.rsp_valid;
	assign rsp_out = q.rsp;
	assign settings_out = q.set;
	assign reload_out = q.reload;

endmodule : supply_register_map

// file: verif/supply_map_checker_sva.sv
// assertions on the ports of the supply register map
`timescale 1ns/100ps
module supply_map_checker (
	// clock and reset
	input  wire logic                         clk_in,
	input  wire logic                         srst_in,
	// request and answer
	input  wire logic                         req_valid_in,
	input  wire supply_map_pkg::request_t     req_in,
	input  wire logic                         rsp_valid_out,
	input  wire supply_map_pkg::response_t    rsp_out,
	// plant and settings
	input  wire supply_map_pkg::plant_flags_t flags_in,
	input  wire logic [63:0]                  opstat_in,
	input  wire supply_map_pkg::measure_t     meas_in,
	input  wire supply_map_pkg::settings_t    settings_out,
	input  wire logic                         reload_out
);
	// ----------------
	// properties
	// ----------------
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (srst_in);

	ans_strobe_a: assert property (req_valid_in |=> rsp_valid_out)
		else $error("answer strobe missing");
	no_spur_a: assert property (!req_valid_in |=> !rsp_valid_out)
		else $error("answer without request");
	addr_echo_a: assert property (req_valid_in |=> rsp_out.addr == $past(req_in.addr))
		else $error("address not echoed");
	bad_func_a: assert property (req_valid_in && !(req_in.func inside {8'h03, 8'h06, 8'h10})
		|=> rsp_out.exc && rsp_out.exc_code == 8'h01) else $error("bad function not refused");
	summary_ro_a: assert property (req_valid_in && req_in.func inside {8'h06, 8'h10}
		&& req_in.addr == 16'h10b0 |=> rsp_out.exc_code == 8'h02) else $error("summary written");
	reload_clear_a: assert property (req_valid_in && req_in.func == 8'h06 && req_in.addr == 16'h8010
		|=> reload_out && settings_out == '0) else $error("reload did not clear");
	reload_cause_a: assert property (reload_out |-> $past(req_valid_in) && $past(req_in.addr) == 16'h8010)
		else $error("reload without request");
	meas_read_a: assert property (req_valid_in && req_in.func == 8'h03 && req_in.addr == 16'h2030
		&& req_in.count == 16'h0002 |=> rsp_out.rdata == {32'h0, $past(meas_in.power_measure_query)})
		else $error("power reading wrong");
	exc_flag_a: assert property (rsp_valid_out && rsp_out.exc |-> rsp_out.func[7] && rsp_out.rdata == '0)
		else $error("exception answer malformed");

	reload_c: cover property (reload_out);
	exc_c: cover property (rsp_valid_out && rsp_out.exc);
	read_c: cover property (rsp_valid_out && !rsp_out.exc && rsp_out.func == 8'h03);
endmodule : supply_map_checker

// file: verif/modbus_master_model.sv
// master issuing one register request at a time
`timescale 1ns/100ps
module modbus_master_model (
	// clock
	input  wire logic                      clk_in,
	// request to the map
	output logic                           req_valid_out,
	output supply_map_pkg::request_t       req_out,
	// answer from the map
	input  wire logic                      rsp_valid_in,
	input  wire supply_map_pkg::response_t rsp_in
);
	initial begin
		req_valid_out = 1'b0;
		req_out = '0;
	end
	// one value per request, consecutive registers, high register in wdata[31:16]
	task automatic xfer(input logic [7:0] f, input logic [15:0] a, input logic [15:0] c,
		input logic [31:0] w, output supply_map_pkg::response_t r, output logic ok);
		@(negedge clk_in);
		req_valid_out = 1'b1;
		req_out = '{f, a, c, w};
		@(negedge clk_in);
		req_valid_out = 1'b0;
		req_out = ~req_out;
		ok = rsp_valid_in;
		r = rsp_in;
	endtask : xfer
endmodule : modbus_master_model

// file: verif/supply_register_map_tb.sv
// self-checking bench of the supply register map
`timescale 1ns/100ps
module supply_register_map_tb;
	logic                         clk_in = 1'b0;
	logic                         srst_in = 1'b1;
	logic                         req_valid_in;
	supply_map_pkg::request_t     req_in;
	logic                         rsp_valid_out;
	supply_map_pkg::response_t    rsp_out;
	supply_map_pkg::plant_flags_t flags_in = '0;
	logic [63:0]                  opstat_in = 64'h0123_4567_89ab_cdef;
	supply_map_pkg::measure_t     meas_in = '{32'h4040_0000, 32'h409f_ff60, 32'h4120_0000};
	supply_map_pkg::settings_t    settings_out;
	logic                         reload_out;
	supply_map_pkg::response_t    rsp;
	logic                         ok;
	int                           errors = 0;
	int                           checks_done = 0;
	int                           cycles = 0;

	// ----------------
	// clock, instances, timeout
	// ----------------
	always #12.5 clk_in = ~clk_in;
	supply_register_map u_supply_register_map (.clk_in(clk_in), .srst_in(srst_in), .req_valid_in(req_valid_in),
		.req_in(req_in), .rsp_valid_out(rsp_valid_out), .rsp_out(rsp_out), .flags_in(flags_in),
		.opstat_in(opstat_in), .meas_in(meas_in), .settings_out(settings_out), .reload_out(reload_out));
	modbus_master_model u_modbus_master_model (.clk_in(clk_in), .req_valid_out(req_valid_in),
		.req_out(req_in), .rsp_valid_in(rsp_valid_out), .rsp_in(rsp_out));
	always @(posedge clk_in) begin
		cycles++;
		if (cycles == 20000) begin
			errors++;
			give_verdict();
		end
	end

	// ----------------
	// tasks
	// ----------------
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		checks_done++;
		if (got !== exp) begin
			errors++;
			$display("ERROR at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic rq(input logic [7:0] f, input logic [15:0] a, input logic [15:0] c, input logic [31:0] w);
		u_modbus_master_model.xfer(f, a, c, w, rsp, ok);
		chk({63'h0, ok}, 64'h1);
	endtask : rq
	function automatic logic [31:0] summary(supply_map_pkg::plant_flags_t f);
		return {16'h0, f.user_input_fault_flag, f.input_power_loss_flag, f.interlock_open_flag,
			f.overvoltage_protect_flag | f.overcurrent_protect_flag | f.overtemp_protect_flag | f.sense_line_loss_flag,
			f.overcurrent_trip_flag | f.overvoltage_trip_flag | f.overpower_trip_flag | f.undervoltage_trip_flag,
			f.const_power_state, f.const_resistance_state, f.const_voltage_state, f.const_current_state,
			f.sense_line_loss_flag, f.overtemp_protect_flag, f.overcurrent_protect_flag, f.overpower_trip_flag,
			f.overvoltage_trip_flag, f.overcurrent_trip_flag, f.overvoltage_protect_flag};
	endfunction : summary
	task automatic t_words();
		logic [15:0] wa [13] = '{16'h3010, 16'h3030, 16'h3050, 16'h4010, 16'h4030, 16'h4050, 16'h4070,
			16'h5010, 16'h5030, 16'h5050, 16'h5090, 16'h50b0, 16'h50d0};
		for (int i = 0; i < 13; i++) begin
			rq(8'h10, wa[i], 16'h0002, {wa[i], ~wa[i]});
			chk({32'h0, settings_out.word[i]}, {32'h0, wa[i], ~wa[i]});
			rq(8'h03, wa[i] + 16'h0010, 16'h0002, 32'h0);
			chk(rsp.rdata, {32'h0, wa[i], ~wa[i]});
		end
	endtask : t_words
	task automatic t_halves();
		logic [15:0] hw [5] = '{16'h6030, 16'h8030, 16'h8060, 16'h8080, 16'h80a0};
		logic [15:0] hr [5] = '{16'h6040, 16'h8020, 16'h8070, 16'h8090, 16'h80b0};
		for (int i = 0; i < 5; i++) begin
			rq(8'h06, hw[i], 16'h0001, {16'h0, hr[i]});
			chk({48'h0, settings_out.half[i]}, {48'h0, hr[i]});
			rq(8'h03, hr[i], 16'h0001, 32'h0);
			chk(rsp.rdata, {48'h0, hr[i]});
		end
	endtask : t_halves
	task automatic t_status();
		for (int i = 0; i < 15; i++) begin
			flags_in = supply_map_pkg::plant_flags_t'(15'h4000 >> i);
			repeat (3) @(negedge clk_in);
			rq(8'h03, 16'h10b0, 16'h0002, 32'h0);
			chk(rsp.rdata, {32'h0, summary(flags_in)});
			rq(8'h03, 16'h10b0, 16'h0002, 32'h0);
			chk(rsp.rdata, {32'h0, summary(flags_in)});
		end
		flags_in = '0;
		rq(8'h03, 16'h10d0, 16'h0004, 32'h0);
		chk(rsp.rdata, opstat_in);
		opstat_in = 64'hfedc_ba98_7654_3210;
		repeat (3) @(negedge clk_in);
		rq(8'h03, 16'h10d0, 16'h0004, 32'h0);
		chk(rsp.rdata, 64'hfedc_ba98_7654_3210);
		rq(8'h03, 16'h2010, 16'h0002, 32'h0);
		chk(rsp.rdata, {32'h0, meas_in.current_measure_query});
		rq(8'h03, 16'h2020, 16'h0002, 32'h0);
		chk(rsp.rdata, {32'h0, meas_in.voltage_measure_query});
		rq(8'h03, 16'h2030, 16'h0002, 32'h0);
		chk(rsp.rdata, {32'h0, meas_in.power_measure_query});
	endtask : t_status
	task automatic t_outen();
		rq(8'h06, 16'h10f0, 16'h0001, 32'h1);
		rq(8'h03, 16'h1100, 16'h0001, 32'h0);
		chk(rsp.rdata, 64'h1);
		flags_in.overcurrent_trip_flag = 1'b1;
		repeat (4) @(negedge clk_in);
		rq(8'h03, 16'h1100, 16'h0001, 32'h0);
		chk(rsp.rdata, 64'h0);
		rq(8'h06, 16'h10f0, 16'h0001, 32'h1);
		rq(8'h03, 16'h1100, 16'h0001, 32'h0);
		chk(rsp.rdata, 64'h0);
		flags_in = '0;
	endtask : t_outen
	task automatic t_errors();
		logic [47:0] tb [6] = '{{8'h03, 16'h10b0, 16'h1, 8'h02}, {8'h06, 16'h10b0, 16'h1, 8'h02},
			{8'h03, 16'h8010, 16'h1, 8'h02}, {8'h04, 16'h3020, 16'h2, 8'h01},
			{8'h10, 16'h2010, 16'h2, 8'h02}, {8'h03, 16'h10d0, 16'h2, 8'h02}};
		for (int i = 0; i < 6; i++) begin
			rq(tb[i][47:40], tb[i][39:24], tb[i][23:8], 32'h0);
			chk({47'h0, rsp.func, rsp.exc, rsp.exc_code}, {47'h0, tb[i][47:40] | 8'h80, 1'b1, tb[i][7:0]});
		end
	endtask : t_errors
	task automatic t_reload();
		rq(8'h10, 16'h3030, 16'h0002, 32'h1234_5678);
		rq(8'h06, 16'h8010, 16'h0001, 32'h1);
		chk({63'h0, reload_out}, 64'h1);
		chk({63'h0, settings_out === '0}, 64'h1);
		rq(8'h03, 16'h3040, 16'h0002, 32'h0);
		chk(rsp.rdata, 64'h0);
	endtask : t_reload
	task automatic give_verdict();
		$display("checks %0d errors %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : give_verdict

	initial begin
		repeat (20) @(negedge clk_in);
		srst_in = 1'b0;
		t_words();
		t_halves();
		t_status();
		t_outen();
		t_errors();
		t_reload();
		give_verdict();
	end
endmodule : supply_register_map_tb

bind supply_register_map supply_map_checker u_supply_map_checker (.clk_in(clk_in), .srst_in(srst_in),
	.req_valid_in(req_valid_in), .req_in(req_in), .rsp_valid_out(rsp_valid_out), .rsp_out(rsp_out),
	.flags_in(flags_in), .opstat_in(opstat_in), .meas_in(meas_in), .settings_out(settings_out),
	.reload_out(reload_out));
